// file: rtl/ahp_host_port.sv
// Parallel host port of a four-channel simultaneous-sampling 14-bit converter.
// Assumes host strobes and conversion start are synchronous to i_clk; results
// arrive from the converter core on i_result and are sampled as each channel ends.
//
// Contract
// R1 - Power-save request high means normal operation, low means standby.
// R2 - Results are 14-bit two's complement, data line 13 is the MSB.
// R3 - Data lines 4 to 13 are three-state outputs, enabled only by reads.
// R4 - Data lines 0 to 3 are bidirectional; host drives them only during writes.
// R5 - Host writes channel selection on lower data lines under chip select.
// R6 - Selection bit 0 maps to channel 1, bit 3 to channel 4.
// R7 - End-of-conversion pulses low after each channel conversion completes.
// R8 - Selection latched at write strobe rising edge with chip select low, read high.
// R9 - Data outputs enabled only while read strobe and chip select are low.
// R10 - Busy rises at conversion start rising edge, stays high until sequence done.
// R11 - Selection bit one includes its channel in the next sequence, zero excludes.
module ahp_host_port
  import ahp_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  input  wire logic              i_chip_select_n,
  input  wire logic              i_read_n,
  input  wire logic              i_write_n,
  input  wire logic              i_conversion_start_n,
  input  wire logic              i_power_save_request_n,
  input  wire logic [3:0]        i_data_low,
  input  wire logic [DATA_W-1:0] i_result,
  output logic      [DATA_W-1:0] o_data,
  output logic      [DATA_W-1:0] o_data_oe_n,
  output logic                   o_busy,
  output logic                   o_end_of_conversion_n,
  output logic                   o_standby,
  output logic      [1:0]        o_channel
);

  logic [3:0]        channel_selection;
  logic [3:0]        seq_mask;
  logic [DATA_W-1:0] result_hold;
  logic              write_n_d;
  logic              start_n_d;
  logic [CNT_W-1:0]  conv_cnt;
  logic [1:0]        chan;
  logic              eoc_n;
  ahp_state_t        state;
  ahp_state_t        next_state;

  wire read_enable  = ~i_read_n & ~i_chip_select_n;
  wire write_rise   = ~write_n_d & i_write_n;
  wire write_take   = write_rise & ~i_chip_select_n & i_read_n;
  wire start_rise   = ~start_n_d & i_conversion_start_n;
  wire standby      = ~i_power_save_request_n;
  wire conv_done    = (conv_cnt == CNT_W'(CONV_CYCLES - 1));

  // One-hot of the channel now converting, and of it with every lower channel.
  wire [3:0] chan_onehot    = 4'h0001 << chan;
  wire [3:0] chan_and_below = chan_onehot | (chan_onehot - 4'h0001);

  // Channels of the frozen sequence that still wait behind the current one.
  wire [3:0] rest           = seq_mask & ~chan_and_below;
  wire       more_left      = |rest;

  // The index wraps in two bits, but a wrapped step lands on a channel that
  // is already cleared in rest, so it can never be picked by mistake.
  wire [1:0] step_one       = chan + 2'd1;
  wire [1:0] step_two       = chan + 2'd2;
  wire [1:0] step_three     = chan + 2'd3;
  wire       take_one       = rest[step_one];
  wire       take_two       = rest[step_two];
  wire [1:0] next_chan      = take_one ? step_one :
                              take_two ? step_two : step_three;

  // Lowest selected channel converts first when a sequence is launched.
  wire [1:0] first_chan = channel_selection[0] ? 2'd0 :
                          channel_selection[1] ? 2'd1 :
                          channel_selection[2] ? 2'd2 : 2'd3;

  // Standby blocks new sequences; a started one is allowed to finish. [R1]
  assign o_standby   = standby;
  assign o_data_oe_n = {DATA_W{~read_enable}}; // [R3] [R4] [R9]
  assign o_data      = result_hold;            // [R2]
  assign o_busy      = (state != AHP_IDLE);    // [R10]
  assign o_end_of_conversion_n = eoc_n;
  assign o_channel   = chan;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      write_n_d <= 1'b1;
      start_n_d <= 1'b1;
    end else begin
      write_n_d <= i_write_n;
      start_n_d <= i_conversion_start_n;
    end
  end

  // Lower data lines map bit n to channel n+1. [R5] [R6] [R8]
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      channel_selection <= CHAN_SEL_RESET;
    end else if (write_take) begin
      channel_selection <= i_data_low;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      AHP_IDLE: begin
        if (start_rise && !standby && (|channel_selection)) begin
          next_state = AHP_CONVERT;
        end
      end
      AHP_CONVERT: begin
        if (conv_done) begin
          next_state = more_left ? AHP_NEXT : AHP_IDLE;
        end
      end
      AHP_NEXT: begin
        next_state = AHP_CONVERT;
      end
      default: begin
        next_state = AHP_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state <= AHP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Named phases of the sequencer, shared by the registers below.
  wire seq_launch  = (state == AHP_IDLE) && (next_state == AHP_CONVERT);
  wire in_convert  = (state == AHP_CONVERT);
  wire in_next     = (state == AHP_NEXT);
  wire channel_end = in_convert && conv_done;

  // The selection is frozen at start so later writes affect only the next sequence. [R11]
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      seq_mask <= 4'h0000;
    end else if (seq_launch) begin
      seq_mask <= channel_selection; // [R11]
    end
  end

  // The channel index loads the first selected channel at launch, then moves only in the one-cycle gap between two channels.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      chan <= 2'd0;
    end else if (seq_launch) begin
      chan <= first_chan; // [R11]
    end else if (in_next) begin
      chan <= next_chan;
    end
  end

  // Cycle counter of the channel now converting; it restarts for every channel.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      conv_cnt <= '0;
    end else if (seq_launch) begin
      conv_cnt <= '0;
    end else if (in_convert) begin
      conv_cnt <= conv_done ? '0 : conv_cnt + CNT_W'(1);
    end
  end

  // EOC pulses low for one cycle after each channel. [R7]
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      eoc_n <= 1'b1;
    end else begin
      eoc_n <= ~channel_end; // [R7]
    end
  end

  // The result is taken in the same cycle as the pulse, so a host that reads on
  // the falling EOC edge always sees the channel that has just finished.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      result_hold <= 14'h0000;
    end else if (channel_end) begin
      result_hold <= i_result; // [R2]
    end
  end

endmodule : ahp_host_port

// file: rtl/ahp_pkg.sv
// Package for the converter's parallel host port: widths, reset values and timing counts.
// Assumes a single 10 MHz system clock and host strobes synchronous to it.
package ahp_pkg;
  localparam int unsigned  DATA_W           = 14;
  localparam int unsigned  NCHAN            = 4;
  localparam int unsigned  SEL_LSB          = 0;
  localparam logic [3:0]   CHAN_SEL_RESET   = 4'h000F;
  localparam int unsigned  CLK_PERIOD_NS    = 100;
  // Conversion time of one channel in nanoseconds, rounded up to whole clock cycles below.
  localparam int unsigned  CONV_TIME_NS     = 2500;
  localparam int unsigned  CONV_CYCLES      = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Width of the end-of-conversion low pulse.
  localparam int unsigned  EOC_PULSE_CYCLES = 1;
  localparam int unsigned  CNT_W            = 5;

  typedef enum logic [2:0] {
    AHP_IDLE    = 3'b001,
    AHP_CONVERT = 3'b010,
    AHP_NEXT    = 3'b100
  } ahp_state_t;
endpackage : ahp_pkg

// file: verif/ahp_checker.sv
// Assertions on the host port, bound to its top module.
// Assumes one clock domain and the asynchronous active-high reset.
module ahp_checker
  import ahp_pkg::*;
(
  input wire logic              i_clk, i_reset, i_chip_select_n, i_read_n,
  input wire logic              i_conversion_start_n, i_power_save_request_n,
  input wire logic [DATA_W-1:0] o_data, o_data_oe_n,
  input wire logic              o_busy, o_end_of_conversion_n, o_standby
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  oe_gate_a: assert property (o_data_oe_n == {DATA_W{i_chip_select_n | i_read_n}})
    else $error("oe");
  standby_map_a: assert property (o_standby == !i_power_save_request_n)
    else $error("power_save_request_n");
  eoc_short_a: assert property (!o_end_of_conversion_n |=> o_end_of_conversion_n)
    else $error("eoc");
  eoc_in_seq_a: assert property (!o_end_of_conversion_n |-> $past(o_busy))
    else $error("eoc idle");
  busy_cause_a: assert property ($rose(o_busy) |-> $past(i_conversion_start_n))
    else $error("busy");
  busy_hold_a: assert property ($rose(o_busy) |=> o_busy [*8])
    else $error("busy short");
  busy_end_a: assert property ($fell(o_busy) |-> !o_end_of_conversion_n)
    else $error("busy end");
  data_seq_a: assert property (!$stable(o_data) |-> $past(o_busy))
    else $error("data");
endmodule : ahp_checker

bind ahp_host_port ahp_checker u_checker (.*);

// file: verif/ahp_host_model.sv
// Host model: strobes, conversion start and the shared lower data lines.
// Assumes its tasks are called just after a rising edge of i_clk.
module ahp_host_model (
  input  wire logic i_clk,
  output logic      o_cs_n, o_rd_n, o_wr_n, o_start_n,
  output logic [3:0] o_data_low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] val = 4'h0;
  logic       drive = 1'h0;
  // A released bus shows the inverse, so a stale value cannot pass.
  assign o_data_low = drive ? val : ~val;
  initial {o_cs_n, o_rd_n, o_wr_n, o_start_n} = 4'hF;
  task automatic write(input logic [3:0] v, input logic rd_n);
    val = v;
    {o_cs_n, o_rd_n, o_wr_n, drive} = {1'h0, rd_n, 2'h1};
    @(posedge i_clk) #1 o_wr_n = 1'h1;
    @(posedge i_clk) #1 {o_cs_n, o_rd_n, drive} = 3'h6;
  endtask : write
  task automatic lines(input logic [1:0] v);
    {o_cs_n, o_rd_n} = v;
  endtask : lines
  task automatic start();
    o_start_n = 1'h0;
    @(posedge i_clk) #1 o_start_n = 1'h1;
  endtask : start
endmodule : ahp_host_model

// file: verif/testbench.sv
// Self-checking bench for the host port, driven through the host model.
// Assumes a 10 MHz clock; the core result is a constant word per row.
module testbench
  import ahp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'h0, i_reset = 1'h1, power_save_request_n_n = 1'h1;
  logic [DATA_W-1:0] result = 14'h0, exp_d = 14'h0;
  wire logic cs_n, rd_n, wr_n, start_n, busy, eoc_n, standby;
  wire logic [3:0] low;
  wire logic [1:0] chan;
  wire logic [DATA_W-1:0] data, oe_n;
  int mismatches = 0, checks_done = 0, cycles = 0;
  // Row: selection, expected channel mask, core result.
  logic [23:0] rows [5] = '{24'h11_2ABC, 24'h88_1FFF, 24'hAA_2000, 24'hFF_0001, 24'h00_3FFF};
  ahp_host_model u_host (.i_clk(i_clk), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n),
    .o_start_n(start_n), .o_data_low(low));
  ahp_host_port u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_chip_select_n(cs_n),
    .i_read_n(rd_n), .i_write_n(wr_n), .i_conversion_start_n(start_n),
    .i_power_save_request_n(power_save_request_n_n), .i_data_low(low), .i_result(result), .o_data(data),
    .o_data_oe_n(oe_n), .o_busy(busy), .o_end_of_conversion_n(eoc_n), .o_standby(standby),
    .o_channel(chan));
  initial forever #50 i_clk = ~i_clk;
  task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // The window covers four channels of 25 cycles plus the gaps between them.
  task automatic run(input logic [3:0] mask);
    logic [3:0] seen;
    int         busy_cycles;
    int         n_sel;
    int         exp_busy;
    seen = 4'h0;
    busy_cycles = 0;
    n_sel = $countones(mask);
    exp_busy = (n_sel == 0) ? 0 : n_sel * int'(CONV_CYCLES) + n_sel - 1;
    u_host.start();
    repeat (130) begin
      @(posedge i_clk) #1;
      if (eoc_n === 1'h0) seen[chan] = 1'h1;
      if (busy === 1'h1) busy_cycles++;
    end
    check("chans", 14'(seen), 14'(mask));
    check("busy_len", 14'(busy_cycles), 14'(exp_busy));
    check("busy_end", 14'(busy), 14'h0);
    if (mask != 4'h0) exp_d = result;
    u_host.lines(2'h0);
    #1 check("oe", oe_n, 14'h0);
    check("data", data, exp_d);
    u_host.lines(2'h3);
  endtask : run
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    repeat (4) @(posedge i_clk);
    #1 i_reset = 1'h0;
    check("idle", oe_n, 14'h3FFF);
    result = 14'h2ABC;
    run(4'hF);
    foreach (rows[i]) begin
      u_host.write(rows[i][23:20], 1'h1);
      result = rows[i][13:0];
      run(rows[i][19:16]);
    end
    u_host.write(4'h3, 1'h0);
    run(4'h0);
    u_host.write(4'h3, 1'h1);
    power_save_request_n_n = 1'h0;
    #1 check("power_save_request_n", 14'(standby), 14'h1);
    run(4'h0);
    power_save_request_n_n = 1'h1;
    run(4'h3);
    end_of_test();
  end
endmodule : testbench
